// File: lpec_pkg.sv
// constants, types and register map of the line performance counters
`default_nettype none
package lpec_pkg;

    // register word indices; byte address is four times the index
    localparam logic [9:0] REG_ACCESS_INDEX = 10'h00E;
    localparam logic [9:0] REG_ACCESS_DATA  = 10'h00F;
    localparam logic [9:0] REG_SNAP_CTRL    = 10'h0C2;
    localparam logic [9:0] REG_OVF_EN0      = 10'h0C3;
    localparam logic [9:0] REG_OVF_EN1      = 10'h0C4;
    localparam logic [9:0] REG_OVF_FLAGS0   = 10'h0C5;
    localparam logic [9:0] REG_OVF_FLAGS1   = 10'h0C6;
    localparam logic [9:0] REG_FORMAT       = 10'h0C8;

    // indirect holding register indices
    localparam logic [3:0] ID_CRC_LO   = 4'h0;
    localparam logic [3:0] ID_CRC_HI   = 4'h1;
    localparam logic [3:0] ID_FER_LO   = 4'h2;
    localparam logic [3:0] ID_FER_HI   = 4'h3;
    localparam logic [3:0] ID_COFA     = 4'h4;
    localparam logic [3:0] ID_OOF      = 4'h5;
    localparam logic [3:0] ID_PATTERN_RECEIVER_LO  = 4'h6;
    localparam logic [3:0] ID_PATTERN_RECEIVER_HI  = 4'h7;
    localparam logic [3:0] ID_LCV_LO   = 4'h8;
    localparam logic [3:0] ID_LCV_HI   = 4'h9;
    localparam logic [3:0] ID_DDS_LO   = 4'hA;
    localparam logic [3:0] ID_DDS_HI   = 4'hB;

    // field positions
    localparam int CTRL_TRIG_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int OVF0_FER_BIT  = 0;
    localparam int OVF0_CRC_BIT  = 1;
    localparam int OVF0_COFA_BIT = 2;
    localparam int OVF0_OOF_BIT  = 3;
    localparam int OVF0_PATTERN_RECEIVER_BIT = 4;
    localparam int OVF0_DDS_BIT  = 5;
    localparam int OVF0_BITS     = 6;
    localparam int OVF1_LCV_BIT  = 0;

    // counter widths
    localparam int LCV_W  = 16;
    localparam int FER_W  = 12;
    localparam int CRC_W  = 10;
    localparam int DDS_W  = 10;
    localparam int COFA_W = 3;
    localparam int OOF_W  = 5;
    localparam int PATTERN_RECEIVER_W = 16;

    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] RST_INDEX = 4'h0;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // snapshot interval
    localparam int unsigned ONE_SECOND_MS = 1000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SNAP_PERIOD_CYCLES =
        (ONE_SECOND_MS * 1000000) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        FMT_SF,
        FMT_ESF,
        FMT_DM,
        FMT_SLC
    } lpec_format_e;

    typedef struct packed {
        logic line_code_viol;
        logic frame_bit_err;
        logic crc_err;
        logic data_pattern_err;
        logic align_change;
        logic sync_loss;
        logic pattern_err;
    } lpec_events_s;

endpackage
`default_nettype wire

// File: lpec_counter.sv
// saturating event counter with snapshot holding register
`timescale 1ns/1ps
`default_nettype none
module lpec_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             inc,
    input  wire logic             snap,
    output logic [WIDTH-1:0]      held,
    output logic                  ovf
);
    localparam logic [WIDTH-1:0] MAX_CNT = '1;
    localparam logic [WIDTH-1:0] ONE_CNT = WIDTH'(1);

    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] held_ff;
    logic             ovf_ff;
    logic             at_max;

    assign at_max = (cnt_ff == MAX_CNT);
    assign held   = held_ff;
    assign ovf    = ovf_ff;

    // live count: clears on snapshot, saturates at max
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_ff <= '0;
        else if (snap)
            cnt_ff <= '0;
        else if (inc && !at_max)
            cnt_ff <= cnt_ff + ONE_CNT;
    end

    // capture includes an event arriving with the snapshot
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            held_ff <= '0;
        else if (snap)
            held_ff <= at_max ? MAX_CNT : cnt_ff + WIDTH'(inc);
    end

    // overflow pulse when an event finds the count full
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ovf_ff <= 1'b0;
        else
            ovf_ff <= inc && at_max;
    end

    chk_cnt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        snap |=> cnt_ff == '0)
        else $error("count not cleared by snapshot");

    chk_event_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        (snap && inc && !at_max) |=> held_ff == $past(cnt_ff) + ONE_CNT)
        else $error("event lost at snapshot");

    chk_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (at_max && !snap) |=> (cnt_ff == MAX_CNT))
        else $error("counter wrapped instead of holding");

    chk_ovf_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        (inc && at_max) |=> ovf_ff ##1 (ovf_ff == $past(inc && at_max)))
        else $error("overflow pulse wrong");

endmodule // lpec_counter
`default_nettype wire

// File: lpec_top.sv
// performance counter bank with snapshot, indirect access and AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module lpec_top
    import lpec_pkg::*;
#(
    parameter int unsigned SNAP_PERIOD = SNAP_PERIOD_CYCLES
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [11:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [11:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire lpec_events_s events,
    output logic              irq
);
    // bus state
    logic [9:0]            aw_idx_ff;
    logic                  aw_full_ff;
    logic [7:0]            w_data_ff;
    logic                  w_lane_ff;
    logic                  w_full_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  rvalid_ff;
    logic [1:0]            rresp_ff;
    logic [31:0]           rdata_ff;
    logic                  wr_go;
    logic                  rd_go;
    logic [9:0]            ar_idx;
    logic                  wr_hit;
    logic                  rd_hit;
    logic [7:0]            rd_byte;

    // control and status
    logic [3:0]            index_ff;
    logic                  trig_ff;
    logic                  auto_en_ff;
    lpec_format_e          fmt_ff;
    logic [OVF0_BITS-1:0]  en0_ff;
    logic                  en1_ff;
    logic [OVF0_BITS-1:0]  flags0_ff;
    logic                  flags1_ff;
    logic [OVF0_BITS-1:0]  set0;
    logic [OVF0_BITS-1:0]  clr0;
    logic                  clr1;
    logic [31:0]           timer_ff;
    logic                  auto_tick;
    logic                  manual_rise;
    logic                  snap;
    logic [7:0]            held_byte;

    // counters
    logic [LCV_W-1:0]      lcv_held;
    logic [FER_W-1:0]      fer_held;
    logic [CRC_W-1:0]      crc_held;
    logic [DDS_W-1:0]      dds_held;
    logic [COFA_W-1:0]     cofa_held;
    logic [OOF_W-1:0]      oof_held;
    logic [PATTERN_RECEIVER_W-1:0]     pattern_receiver_held;
    logic                  lcv_ovf;
    logic                  fer_ovf;
    logic                  crc_ovf;
    logic                  dds_ovf;
    logic                  cofa_ovf;
    logic                  oof_ovf;
    logic                  pattern_receiver_ovf;
    logic                  crc_inc;
    logic                  dds_inc;

    // bus handshakes
    assign s_axi_awready = !aw_full_ff && !bvalid_ff;
    assign s_axi_wready  = !w_full_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign wr_go  = aw_full_ff && w_full_ff && !bvalid_ff;
    assign rd_go  = s_axi_arvalid && !rvalid_ff;
    assign ar_idx = s_axi_araddr[11:2];

    // write address and data are taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            aw_idx_ff  <= 10'h000;
            w_data_ff  <= RST_BYTE;
            w_lane_ff  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_ff <= 1'b1;
                aw_idx_ff  <= s_axi_awaddr[11:2];
            end
            else if (wr_go)
                aw_full_ff <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_ff <= 1'b1;
                w_data_ff <= s_axi_wdata[7:0];
                w_lane_ff <= s_axi_wstrb[0];       // only the low lane holds data
            end
            else if (wr_go)
                w_full_ff <= 1'b0;
        end
    end

    // write address decode
    always_comb
    begin
        unique case (aw_idx_ff)
            REG_ACCESS_INDEX, REG_ACCESS_DATA, REG_SNAP_CTRL,
            REG_OVF_EN0, REG_OVF_EN1, REG_OVF_FLAGS0,
            REG_OVF_FLAGS1, REG_FORMAT: wr_hit = 1'b1;
            default:                    wr_hit = 1'b0;
        endcase
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    // control registers written by software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            index_ff   <= RST_INDEX;
            trig_ff    <= 1'b0;
            auto_en_ff <= 1'b0;
            fmt_ff     <= FMT_SF;
            en0_ff     <= '0;
            en1_ff     <= 1'b0;
        end
        else if (wr_go && w_lane_ff)
        begin
            unique case (aw_idx_ff)
                REG_ACCESS_INDEX: index_ff <= w_data_ff[3:0];
                REG_SNAP_CTRL:
                begin
                    trig_ff    <= w_data_ff[CTRL_TRIG_BIT];
                    auto_en_ff <= w_data_ff[CTRL_AUTO_BIT];
                end
                REG_FORMAT:  fmt_ff <= lpec_format_e'(w_data_ff[1:0]);
                REG_OVF_EN0: en0_ff <= w_data_ff[OVF0_BITS-1:0];
                REG_OVF_EN1: en1_ff <= w_data_ff[OVF1_LCV_BIT];
                default: ;
            endcase
        end
    end

    // snapshot sources: written trigger edge or one-second tick
    assign manual_rise = wr_go && w_lane_ff && aw_idx_ff == REG_SNAP_CTRL
                         && w_data_ff[CTRL_TRIG_BIT] && !trig_ff;
    assign auto_tick   = auto_en_ff
                         && timer_ff == SNAP_PERIOD - 32'd1;
    assign snap        = manual_rise || auto_tick;

    // one-second interval timer, idle while auto snapshot is off
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_ff <= 32'h0000_0000;
        else if (!auto_en_ff || auto_tick)
            timer_ff <= 32'h0000_0000;
        else
            timer_ff <= timer_ff + 32'd1;
    end

    // format-dependent counter assignment
    assign crc_inc = events.crc_err && fmt_ff == FMT_ESF;
    assign dds_inc = events.data_pattern_err && fmt_ff == FMT_DM;

    // counter bank
    lpec_counter #(.WIDTH(LCV_W)) u_lcv (
        .aclk(aclk), .aresetn(aresetn), .inc(events.line_code_viol),
        .snap(snap), .held(lcv_held), .ovf(lcv_ovf));
    lpec_counter #(.WIDTH(FER_W)) u_fer (
        .aclk(aclk), .aresetn(aresetn), .inc(events.frame_bit_err),
        .snap(snap), .held(fer_held), .ovf(fer_ovf));
    lpec_counter #(.WIDTH(CRC_W)) u_crc (
        .aclk(aclk), .aresetn(aresetn), .inc(crc_inc),
        .snap(snap), .held(crc_held), .ovf(crc_ovf));
    lpec_counter #(.WIDTH(DDS_W)) u_dds (
        .aclk(aclk), .aresetn(aresetn), .inc(dds_inc),
        .snap(snap), .held(dds_held), .ovf(dds_ovf));
    lpec_counter #(.WIDTH(COFA_W)) u_cofa (
        .aclk(aclk), .aresetn(aresetn), .inc(events.align_change),
        .snap(snap), .held(cofa_held), .ovf(cofa_ovf));
    lpec_counter #(.WIDTH(OOF_W)) u_oof (
        .aclk(aclk), .aresetn(aresetn), .inc(events.sync_loss),
        .snap(snap), .held(oof_held), .ovf(oof_ovf));
    lpec_counter #(.WIDTH(PATTERN_RECEIVER_W)) u_pattern_receiver (
        .aclk(aclk), .aresetn(aresetn), .inc(events.pattern_err),
        .snap(snap), .held(pattern_receiver_held), .ovf(pattern_receiver_ovf));

    // overflow sources and write-one-to-clear terms
    always_comb
    begin
        set0 = '0;
        set0[OVF0_FER_BIT]  = fer_ovf;
        set0[OVF0_CRC_BIT]  = crc_ovf;
        set0[OVF0_COFA_BIT] = cofa_ovf;
        set0[OVF0_OOF_BIT]  = oof_ovf;
        set0[OVF0_PATTERN_RECEIVER_BIT] = pattern_receiver_ovf;
        set0[OVF0_DDS_BIT]  = dds_ovf;
        clr0 = '0;
        clr1 = 1'b0;
        if (wr_go && w_lane_ff && aw_idx_ff == REG_OVF_FLAGS0)
            clr0 = w_data_ff[OVF0_BITS-1:0];
        if (wr_go && w_lane_ff && aw_idx_ff == REG_OVF_FLAGS1)
            clr1 = w_data_ff[OVF1_LCV_BIT];
    end

    // sticky overflow flags; a new overflow beats a clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags0_ff <= '0;
            flags1_ff <= 1'b0;
        end
        else
        begin
            flags0_ff <= (flags0_ff & ~clr0) | set0;
            flags1_ff <= (flags1_ff & ~clr1) | lcv_ovf;
        end
    end

    // interrupt from enabled flags only
    assign irq = |(flags0_ff & en0_ff) || (flags1_ff && en1_ff);

    // indirect holding register selection
    always_comb
    begin
        unique case (index_ff)
            ID_CRC_LO:  held_byte = crc_held[7:0];
            ID_CRC_HI:  held_byte = {6'h00, crc_held[9:8]};
            ID_FER_LO:  held_byte = fer_held[7:0];
            ID_FER_HI:  held_byte = {4'h0, fer_held[11:8]};
            ID_COFA:    held_byte = {5'h00, cofa_held};
            ID_OOF:     held_byte = {3'h0, oof_held};
            ID_PATTERN_RECEIVER_LO: held_byte = pattern_receiver_held[7:0];
            ID_PATTERN_RECEIVER_HI: held_byte = pattern_receiver_held[15:8];
            ID_LCV_LO:  held_byte = lcv_held[7:0];
            ID_LCV_HI:  held_byte = lcv_held[15:8];
            ID_DDS_LO:  held_byte = dds_held[7:0];
            ID_DDS_HI:  held_byte = {6'h00, dds_held[9:8]};
            default:    held_byte = RST_BYTE;
        endcase
    end

    // read data mux
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_byte = RST_BYTE;
        unique case (ar_idx)
            REG_ACCESS_INDEX: rd_byte = {4'h0, index_ff};
            REG_ACCESS_DATA:  rd_byte = held_byte;
            REG_SNAP_CTRL:
            begin
                rd_byte[CTRL_TRIG_BIT] = trig_ff;
                rd_byte[CTRL_AUTO_BIT] = auto_en_ff;
            end
            REG_FORMAT:       rd_byte = {6'h00, fmt_ff};
            REG_OVF_EN0:      rd_byte = {2'h0, en0_ff};
            REG_OVF_EN1:      rd_byte = {7'h00, en1_ff};
            REG_OVF_FLAGS0:   rd_byte = {2'h0, flags0_ff};
            REG_OVF_FLAGS1:   rd_byte = {7'h00, flags1_ff};
            default:          rd_hit = 1'b0;
        endcase
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end
        else if (rd_go)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff  <= {24'h000000, rd_byte};
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    chk_auto_tick_snap: assert property (@(posedge aclk) disable iff (!aresetn)
        (auto_en_ff && timer_ff == SNAP_PERIOD - 32'd1) |-> snap
        ##1 (timer_ff == 32'h0000_0000))
        else $error("auto snapshot missed");

    chk_snap_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        (snap && !manual_rise) |-> auto_en_ff)
        else $error("snapshot without a cause");

    chk_manual_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        manual_rise |=> trig_ff ##0 !$past(trig_ff))
        else $error("manual trigger edge wrong");

    chk_crc_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (fmt_ff != FMT_ESF) |-> !crc_inc)
        else $error("crc counted outside extended superframe");

    chk_dds_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (fmt_ff != FMT_DM) |-> !dds_inc)
        else $error("data pattern counted outside multiplex");

    chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (flags0_ff[OVF0_FER_BIT] && !clr0[OVF0_FER_BIT])
        |=> flags0_ff[OVF0_FER_BIT])
        else $error("overflow flag dropped without clear");

    chk_lcv_flag_map: assert property (@(posedge aclk) disable iff (!aresetn)
        lcv_ovf |=> flags1_ff && (flags0_ff == $past(flags0_ff & ~clr0 | set0)))
        else $error("line code overflow misplaced");

    chk_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        (en0_ff == '0 && !en1_ff) |-> !irq)
        else $error("interrupt with all enables off");

    chk_index_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_go && ar_idx == REG_ACCESS_DATA && index_ff == ID_LCV_LO)
        |=> s_axi_rdata == {24'h000000, $past(lcv_held[7:0])})
        else $error("indirect read returned wrong byte");

endmodule // lpec_top
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the line performance counter bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lpec_pkg::*;
    logic         aclk, aresetn;
    logic [11:0]  awaddr, araddr;
    logic         awvalid, wvalid, bready, arvalid, rready;
    logic [31:0]  wdata, rdata;
    logic [3:0]   wstrb;
    logic         awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]   bresp, rresp;
    lpec_events_s ev_in;
    int           n_mismatch, checks_done;
    int           ev_n;
    logic [7:0]   rd_seen, held_a;
    bit           skip_data;

    lpec_top #(.SNAP_PERIOD(50)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .events(ev_in), .irq(irq)
    ); // lpec_top

    // 20 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic final_report;
        $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask

    // one AXI4-Lite write, both channels offered together
    task automatic wr(logic [9:0] idx, logic [7:0] d, logic [1:0] er);
        logic a, w, ta, tw, b;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ta = 0;
        tw = 0;
        b = 0;
        while (!(ta && tw))
        begin
            @(negedge aclk);
            a = awready;
            w = wready;
            @(posedge aclk);
            if (a)
            begin
                ta = 1;
                awvalid <= 1'b0;
            end
            if (w)
            begin
                tw = 1;
                wvalid <= 1'b0;
            end
        end
        while (!b)
        begin
            @(negedge aclk);
            b = bvalid;
            if (b) chk("bresp", {30'h0, er}, {30'h0, bresp});
            @(posedge aclk);
        end
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    // one AXI4-Lite read compared with an expected word
    task automatic rd(logic [9:0] idx, logic [7:0] d, logic [1:0] er);
        logic a, r;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        a = 0;
        r = 0;
        while (!a)
        begin
            @(negedge aclk);
            a = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        while (!r)
        begin
            @(negedge aclk);
            r = rvalid;
            if (r && !skip_data) chk("rdata", {24'h0, d}, rdata);
            if (r) rd_seen = rdata[7:0];
            if (r) chk("rresp", {30'h0, er}, {30'h0, rresp});
            @(posedge aclk);
        end
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rdi(logic [3:0] i, logic [7:0] d);
        wr(REG_ACCESS_INDEX, {4'h0, i}, RESP_OKAY);
        rd(REG_ACCESS_DATA, d, RESP_OKAY);
    endtask

    task automatic ev(logic [6:0] m, int n);
        ev_in <= m;
        repeat (n) @(posedge aclk);
        ev_in <= 7'h00;
        @(posedge aclk);
    endtask

    // manual snapshot through a written 0 to 1 edge
    task automatic snap;
        wr(REG_SNAP_CTRL, 8'h00, RESP_OKAY);
        wr(REG_SNAP_CTRL, 8'h01, RESP_OKAY);
    endtask

    task automatic all(logic [15:0] l, f, c, d, a, o, p);
        rdi(ID_CRC_LO, c[7:0]);
        rdi(ID_CRC_HI, c[15:8]);
        rdi(ID_FER_LO, f[7:0]);
        rdi(ID_FER_HI, f[15:8]);
        rdi(ID_COFA, a[7:0]);
        rdi(ID_OOF, o[7:0]);
        rdi(ID_PATTERN_RECEIVER_LO, p[7:0]);
        rdi(ID_PATTERN_RECEIVER_HI, p[15:8]);
        rdi(ID_LCV_LO, l[7:0]);
        rdi(ID_LCV_HI, l[15:8]);
        rdi(ID_DDS_LO, d[7:0]);
        rdi(ID_DDS_HI, d[15:8]);
    endtask

    task automatic irq_is(logic e);
        @(negedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge aclk);
    endtask

    // bench count of line code events seen at each rising edge
    always @(posedge aclk)
    begin
        if (ev_in.line_code_viol)
            ev_n++;
    end

    // watchdog sized well beyond the expected run
    initial
    begin
        repeat (90000) @(posedge aclk);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        n_mismatch = 0;
        checks_done = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h00000000;
        wstrb = 4'h1;
        ev_in = 7'h00;
        ev_n = 0;
        skip_data = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_SNAP_CTRL, 8'h00, RESP_OKAY);
        rd(REG_OVF_FLAGS0, 8'h00, RESP_OKAY);
        rd(10'h0D0, 8'h00, RESP_SLVERR);
        wr(REG_ACCESS_INDEX, 8'h0B, RESP_OKAY);
        rd(REG_ACCESS_INDEX, 8'h0B, RESP_OKAY);
        // a write with the low strobe off leaves the index alone
        wstrb <= 4'h0;
        wr(REG_ACCESS_INDEX, 8'h05, RESP_OKAY);
        wstrb <= 4'h1;
        rd(REG_ACCESS_INDEX, 8'h0B, RESP_OKAY);
        rdi(4'hC, 8'h00);
        // each format, with crc and data pattern counts gated
        for (int f = 0; f < 4; f++)
        begin
            wr(REG_FORMAT, f[7:0], RESP_OKAY);
            snap();
            ev(7'h7F, 2);
            ev(7'h41, 3);
            snap();
            all(5, 2, (f == 1) ? 2 : 0, (f == 2) ? 2 : 0, 2, 2, 5);
        end
        rd(REG_FORMAT, 8'h03, RESP_OKAY);
        snap();
        all(0, 0, 0, 0, 0, 0, 0);
        // events running through a snapshot edge are all kept
        ev_n = 0;
        ev_in <= 7'h40;
        snap();
        ev_in <= 7'h00;
        wr(REG_ACCESS_INDEX, {4'h0, ID_LCV_LO}, RESP_OKAY);
        skip_data = 1'b1;
        rd(REG_ACCESS_DATA, 8'h00, RESP_OKAY);
        held_a = rd_seen;
        snap();
        rd(REG_ACCESS_DATA, 8'h00, RESP_OKAY);
        skip_data = 1'b0;
        chk("lcv split", ev_n, 32'(held_a) + 32'(rd_seen));
        // saturation, overflow flags, interrupt masking
        ev(7'h44, 65537);
        snap();
        rd(REG_OVF_FLAGS0, 8'h04, RESP_OKAY);
        rd(REG_OVF_FLAGS1, 8'h01, RESP_OKAY);
        rdi(ID_LCV_HI, 8'hFF);
        rdi(ID_COFA, 8'h07);
        irq_is(1'b0);
        wr(REG_OVF_EN1, 8'h01, RESP_OKAY);
        irq_is(1'b1);
        wr(REG_OVF_FLAGS1, 8'h01, RESP_OKAY);
        irq_is(1'b0);
        wr(REG_OVF_EN0, 8'h04, RESP_OKAY);
        rd(REG_OVF_EN0, 8'h04, RESP_OKAY);
        irq_is(1'b1);
        wr(REG_OVF_FLAGS0, 8'h04, RESP_OKAY);
        irq_is(1'b0);
        // automatic snapshot every 50 cycles
        wr(REG_ACCESS_INDEX, {4'h0, ID_LCV_LO}, RESP_OKAY);
        wr(REG_SNAP_CTRL, 8'h02, RESP_OKAY);
        ev(7'h40, 4);
        repeat (50) @(posedge aclk);
        rd(REG_ACCESS_DATA, 8'h04, RESP_OKAY);
        wr(REG_SNAP_CTRL, 8'h00, RESP_OKAY);
        final_report();
    end
endmodule // tb_top
`default_nettype wire
